// ==== hw/fts_fan_monitor.sv ====
// Operation
// - Reading above limit sets fan failure bit
// - Stall loads all-ones reading
// - Slow fan loads FFFEh, or all-ones
// - Stalled reading stays at all-ones
// - Restarting fan restarts measurement, stores count
// - Status needs reading over minimum and enable
// - All-ones minimum never sets status
// - Per-fan enables reset to enabled
// - Group enable resets off, gates pin
// - Full duty is 255/256, not constant
// - Shortest guard is eight tach clocks
// - Three edges measure one tach pulse
// - Two edges measure half a pulse
// - Stretch extends window, 50 to 950 ms
// - No fan events while PWM off
// - Counter overflow counts as slow fan
module fts_fan_monitor (
   input wire logic I_CORE_CLK,
   input wire logic I_ARST_N,
   input wire fts_pkg::fts_reg_req_type I_REG,
   input wire logic [3:0] I_TACH,
   output logic [7:0] O_REG_RDATA,
   output logic [2:0] O_PWM,
   output logic O_FAN_INT_N
);
   localparam int NFAN = fts_pkg::NFAN;
   localparam int NPWM = fts_pkg::NPWM;

   logic [9:0] div_r;
   logic tick_r;
   logic [1:0] step_cnt_r;
   logic step_r;
   logic [NFAN-1:0] tach_meta_r;
   logic [NFAN-1:0] tach_sync_r;
   logic [7:0] duty_r [NPWM];
   logic [15:0] limit_r [NFAN];
   logic [7:0] opt_r [NFAN];
   logic [7:0] msb_shadow_r [NFAN];
   logic [7:0] enable_r;
   logic [7:0] status_r;
   logic [15:0] reading [NFAN];
   logic [NFAN-1:0] stretch_req;
   logic [NPWM-1:0] pwm_stretch;
   logic [NPWM-1:0] pwm_out;
   logic [NFAN-1:0] fan_pwm_on;
   logic [NFAN-1:0] fan_set;
   logic [7:0] status_set;
   logic status_rd;
   logic [7:0] rdata_nxt;
   logic int_nxt;

   // Address window test, shared by write decode and read mux
   function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base,
                                     input int n);
      return (addr >= base) && (addr < 8'(base + 8'(n)));
   endfunction : in_block

   function automatic int block_idx(input logic [7:0] addr, input logic [7:0] base);
      return int'(8'(addr - base));
   endfunction : block_idx

   // 90 kHz tach clock as a one-cycle enable
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         div_r <= 10'h000;
         tick_r <= 1'b0;
      end else if (div_r == 10'(fts_pkg::TICK_DIV - 1)) begin
         div_r <= 10'h000;
         tick_r <= 1'b1;
      end else begin
         div_r <= 10'(div_r + 10'h001);
         tick_r <= 1'b0;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         step_cnt_r <= 2'h0;
         step_r <= 1'b0;
      end else begin
         step_r <= 1'b0;
         if (tick_r) begin
            step_cnt_r <= 2'(step_cnt_r + 2'h1);
            step_r <= (step_cnt_r == 2'(fts_pkg::PWM_STEP_TICKS - 1));
         end
      end
   end

   // Tach pins are asynchronous
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tach_meta_r <= '0;
         tach_sync_r <= '0;
      end else begin
         tach_meta_r <= I_TACH;
         tach_sync_r <= tach_meta_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NFAN; g++) begin : g_fan
         fts_tach u_tach (
            .i_clk(I_CORE_CLK),
            .i_arst_n(I_ARST_N),
            .i_tick(tick_r),
            .i_tach(tach_sync_r[g]),
            .i_pwm_on(pwm_out[fts_pkg::pwm_of_fan(g)]),
            .i_opt(fts_pkg::opt_unpack(opt_r[g])),
            .o_reading(reading[g]),
            .o_stretch_req(stretch_req[g])
         );
         assign fan_pwm_on[g] = pwm_out[fts_pkg::pwm_of_fan(g)];
         assign fan_set[g] = (limit_r[g] != fts_pkg::LIMIT_OFF)
            && (reading[g] > limit_r[g])
            && enable_r[fts_pkg::STAT_FAN_LSB + g]
            && fan_pwm_on[g];
      end
      for (g = 0; g < NPWM; g++) begin : g_pwm
         // PWM stays high until every fan tied to it has measured
         assign pwm_stretch[g] = (g < NPWM - 1) ? stretch_req[g] : |stretch_req[NFAN-1:g];
         fts_pwm u_pwm (
            .i_clk(I_CORE_CLK),
            .i_arst_n(I_ARST_N),
            .i_step(step_r),
            .i_duty(duty_r[g]),
            .i_stretch(pwm_stretch[g]),
            .o_pwm(pwm_out[g])
         );
      end
   endgenerate

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_PWM <= '0;
      end else begin
         O_PWM <= pwm_out;
      end
   end

   // Writable registers
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         enable_r <= fts_pkg::ENABLE_RST;
         for (int i = 0; i < NPWM; i++) begin
            duty_r[i] <= fts_pkg::DUTY_RST;
         end
         for (int i = 0; i < NFAN; i++) begin
            limit_r[i] <= fts_pkg::LIMIT_RST;
            opt_r[i] <= fts_pkg::OPT_RST;
         end
      end else if (I_REG.wr) begin
         if (I_REG.addr == fts_pkg::ADDR_ENABLE) begin
            enable_r <= I_REG.wdata;
         end
         if (in_block(I_REG.addr, fts_pkg::ADDR_DUTY_BASE, NPWM)) begin
            duty_r[block_idx(I_REG.addr, fts_pkg::ADDR_DUTY_BASE)] <= I_REG.wdata;
         end
         if (in_block(I_REG.addr, fts_pkg::ADDR_OPT_BASE, NFAN)) begin
            opt_r[block_idx(I_REG.addr, fts_pkg::ADDR_OPT_BASE)] <= I_REG.wdata;
         end
         if (in_block(I_REG.addr, fts_pkg::ADDR_LIMIT_BASE, 2 * NFAN)) begin
            if (I_REG.addr[0]) begin
               limit_r[block_idx(I_REG.addr, fts_pkg::ADDR_LIMIT_BASE) / 2][15:8]
                  <= I_REG.wdata;
            end else begin
               limit_r[block_idx(I_REG.addr, fts_pkg::ADDR_LIMIT_BASE) / 2][7:0]
                  <= I_REG.wdata;
            end
         end
      end
   end

   // Reading the low byte freezes the high byte for the next read
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         for (int i = 0; i < NFAN; i++) begin
            msb_shadow_r[i] <= 8'h00;
         end
      end else if (I_REG.rd && in_block(I_REG.addr, fts_pkg::ADDR_READ_BASE, 2 * NFAN)
                   && !I_REG.addr[0]) begin
         msb_shadow_r[block_idx(I_REG.addr, fts_pkg::ADDR_READ_BASE) / 2] <=
            reading[block_idx(I_REG.addr, fts_pkg::ADDR_READ_BASE) / 2][15:8];
      end
   end

   always_comb begin
      status_set = 8'h00;
      status_set[fts_pkg::STAT_FAN_LSB +: NFAN] = fan_set;
   end

   assign status_rd = I_REG.rd && (I_REG.addr == fts_pkg::ADDR_STATUS);

   // A new event in the read cycle survives the clear
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         status_r <= 8'h00;
      end else if (status_rd) begin
         status_r <= status_set;
      end else begin
         status_r <= status_r | status_set;
      end
   end

   assign int_nxt = enable_r[fts_pkg::EN_GROUP_BIT] && |(status_r & enable_r);

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_FAN_INT_N <= 1'b1;
      end else begin
         O_FAN_INT_N <= !int_nxt;
      end
   end

   always_comb begin
      rdata_nxt = 8'h00;
      if (I_REG.addr == fts_pkg::ADDR_STATUS) begin
         rdata_nxt = status_r;
      end else if (I_REG.addr == fts_pkg::ADDR_ENABLE) begin
         rdata_nxt = enable_r;
      end else if (in_block(I_REG.addr, fts_pkg::ADDR_DUTY_BASE, NPWM)) begin
         rdata_nxt = duty_r[block_idx(I_REG.addr, fts_pkg::ADDR_DUTY_BASE)];
      end else if (in_block(I_REG.addr, fts_pkg::ADDR_OPT_BASE, NFAN)) begin
         rdata_nxt = opt_r[block_idx(I_REG.addr, fts_pkg::ADDR_OPT_BASE)];
      end else if (in_block(I_REG.addr, fts_pkg::ADDR_LIMIT_BASE, 2 * NFAN)) begin
         rdata_nxt = I_REG.addr[0] ?
            limit_r[block_idx(I_REG.addr, fts_pkg::ADDR_LIMIT_BASE) / 2][15:8] :
            limit_r[block_idx(I_REG.addr, fts_pkg::ADDR_LIMIT_BASE) / 2][7:0];
      end else if (in_block(I_REG.addr, fts_pkg::ADDR_READ_BASE, 2 * NFAN)) begin
         rdata_nxt = I_REG.addr[0] ?
            msb_shadow_r[block_idx(I_REG.addr, fts_pkg::ADDR_READ_BASE) / 2] :
            reading[block_idx(I_REG.addr, fts_pkg::ADDR_READ_BASE) / 2][7:0];
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_REG_RDATA <= 8'h00;
      end else if (I_REG.rd) begin
         O_REG_RDATA <= rdata_nxt;
      end
   end

   sequence seq_status_read;
      I_REG.rd && I_REG.addr == fts_pkg::ADDR_STATUS;
   endsequence

   AST_INT_GROUP_GATE: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      !O_FAN_INT_N |-> $past(enable_r[7]))
      else $error("Interrupt pin active without the group enable");

   AST_INT_DRIVE: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (enable_r[7] && |(status_r & enable_r)) |=> !O_FAN_INT_N)
      else $error("Enabled fan event did not drive the interrupt pin");

   AST_ENABLE_RESET: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      !$past(I_ARST_N) |-> (enable_r[5:2] == 4'hF && !enable_r[7]))
      else $error("Enable register left reset with wrong value");

   AST_OUT_RESET: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      !$past(I_ARST_N) |-> (O_FAN_INT_N && O_PWM == 3'h0 && status_r == 8'h00))
      else $error("Outputs left reset with wrong value");

   AST_TICK_PULSE: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      tick_r |=> !tick_r)
      else $error("Tach tick lasted more than one cycle");

   AST_STEP_ON_TICK: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      step_r |-> $past(tick_r))
      else $error("PWM step without a tach tick");

   AST_STATUS_RSVD: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      status_r[1:0] == 2'h0 && status_r[7:6] == 2'h0)
      else $error("Status bit outside the fan field set");

   AST_STATUS_RDATA: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      seq_status_read |=> O_REG_RDATA == $past(status_r))
      else $error("Status read returned the wrong value");

   AST_STATUS_WR_IGN: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (I_REG.wr && I_REG.addr == fts_pkg::ADDR_STATUS && !status_rd && status_set == 8'h00)
      |=> $stable(status_r))
      else $error("Status write changed the status bits");

   AST_ENABLE_WRITE: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (I_REG.wr && I_REG.addr == fts_pkg::ADDR_ENABLE) |=> enable_r == $past(I_REG.wdata))
      else $error("Enable write did not land");

   AST_ENABLE_RDATA: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (I_REG.rd && I_REG.addr == fts_pkg::ADDR_ENABLE) |=> O_REG_RDATA == $past(enable_r))
      else $error("Enable read returned the wrong value");

   generate
      for (g = 0; g < NFAN; g++) begin : g_ast
         AST_LIMIT_LO_WR: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (I_REG.wr && I_REG.addr == 8'(fts_pkg::ADDR_LIMIT_BASE + 8'(2 * g)))
            |=> limit_r[g][7:0] == $past(I_REG.wdata))
            else $error("Limit low byte write did not land");

         AST_LIMIT_HI_WR: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (I_REG.wr && I_REG.addr == 8'(fts_pkg::ADDR_LIMIT_BASE + 8'(2 * g + 1)))
            |=> limit_r[g][15:8] == $past(I_REG.wdata))
            else $error("Limit high byte write did not land");

         AST_EN_OFF_QUIET: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (!enable_r[2 + g] && !status_r[2 + g]) |=> !status_r[2 + g])
            else $error("Disabled fan set its status bit");

         AST_PWM_OFF_HOLD: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (!fan_pwm_on[g] && !status_r[2 + g]) |=> !status_r[2 + g])
            else $error("Fan with its PWM off set its status bit");

         AST_LIM_OFF_HOLD: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (limit_r[g] == 16'hFFFF && !status_r[2 + g]) |=> !status_r[2 + g])
            else $error("All-ones minimum set a status bit");

         AST_INT_FOLLOWS: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (fan_set[g] && !I_REG.wr && enable_r[7] && enable_r[2 + g]) |-> ##2 !O_FAN_INT_N)
            else $error("Fan event did not reach the interrupt pin");

         AST_FAIL_SET: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (reading[g] > limit_r[g] && limit_r[g] != 16'hFFFF && enable_r[2 + g]
             && fan_pwm_on[g]) |=> status_r[2 + g])
            else $error("Fan over limit did not set its status bit");

         AST_LIMIT_OFF: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            $rose(status_r[2 + g]) |-> $past(limit_r[g]) != 16'hFFFF)
            else $error("Status set with an all-ones minimum");

         AST_EN_NEEDED: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            $rose(status_r[2 + g]) |-> ($past(enable_r[2 + g])
                                        && $past(reading[g]) > $past(limit_r[g])))
            else $error("Status set without enable or over-limit reading");

         AST_PWM_OFF_QUIET: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            $rose(status_r[2 + g]) |-> $past(fan_pwm_on[g]))
            else $error("Fan event raised while its PWM was off");

         AST_STATUS_HOLD: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (status_r[2 + g] && !status_rd) |=> status_r[2 + g])
            else $error("Status bit dropped without a read");

         AST_READ_CLEAR: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
            (seq_status_read ##0 !fan_set[g]) |=> !status_r[2 + g])
            else $error("Status read did not clear an idle bit");
      end
   endgenerate

endmodule : fts_fan_monitor

// ==== hw/fts_pkg.sv ====
package fts_pkg;

   // Timing base
   localparam int CLK_HZ = 50_000_000;
   localparam int TCLK_HZ = 90_000;
   // Tach tick divider, rounded down so no tick is ever late
   localparam int TICK_DIV = CLK_HZ / TCLK_HZ;
   localparam int PWM_STEP_TICKS = 4;
   localparam int NFAN = 4;
   localparam int NPWM = 3;

   // Shortest guard time, 88.88 us, rounded up to tach ticks
   localparam longint GUARD_MIN_PS = 88_880_000;
   localparam int GUARD_MIN_TCK =
      int'((GUARD_MIN_PS * TCLK_HZ + 64'd999_999_999_999) / 64'd1_000_000_000_000);
   localparam int GUARD_SEL1_TCK = 16;
   localparam int GUARD_SEL2_TCK = 32;
   localparam int GUARD_MAX_TCK = 63;

   // Register offsets
   localparam logic [7:0] ADDR_READ_BASE = 8'h28;
   localparam logic [7:0] ADDR_DUTY_BASE = 8'h30;
   localparam logic [7:0] ADDR_STATUS = 8'h42;
   localparam logic [7:0] ADDR_LIMIT_BASE = 8'h54;
   localparam logic [7:0] ADDR_ENABLE = 8'h80;
   localparam logic [7:0] ADDR_OPT_BASE = 8'h90;

   // Field positions and reset values
   localparam int STAT_FAN_LSB = 2;
   localparam int EN_GROUP_BIT = 7;
   localparam logic [7:0] ENABLE_RST = 8'h3C;
   localparam logic [15:0] LIMIT_RST = 16'hFFFF;
   localparam logic [7:0] OPT_RST = 8'h00;
   localparam logic [7:0] DUTY_RST = 8'h80;
   localparam logic [15:0] STALL_CODE = 16'hFFFF;
   localparam logic [15:0] SLOW_CODE = 16'hFFFE;
   localparam logic [15:0] LIMIT_OFF = 16'hFFFF;
   localparam int OPT_SLOW_BIT = 0;
   localparam int OPT_EDGE_LSB = 1;
   localparam int OPT_GUARD_LSB = 3;
   localparam int OPT_STR_LSB = 5;

   typedef struct packed {
      logic [2:0] stretch;
      logic [1:0] guard;
      logic [1:0] edges;
      logic slow;
   } fts_opt_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fts_reg_req_type;

   function automatic fts_opt_type opt_unpack(input logic [7:0] v);
      fts_opt_type o;
      o.stretch = v[OPT_STR_LSB +: 3];
      o.guard = v[OPT_GUARD_LSB +: 2];
      o.edges = v[OPT_EDGE_LSB +: 2];
      o.slow = v[OPT_SLOW_BIT];
      return o;
   endfunction : opt_unpack

   function automatic logic [3:0] edge_need(input logic [1:0] sel);
      unique case (sel)
         2'h0: return 4'h2;
         2'h1: return 4'h3;
         2'h2: return 4'h5;
         default: return 4'h9;
      endcase
   endfunction : edge_need

   function automatic logic [5:0] guard_tck(input logic [1:0] sel);
      unique case (sel)
         2'h0: return 6'(GUARD_MIN_TCK);
         2'h1: return 6'(GUARD_SEL1_TCK);
         2'h2: return 6'(GUARD_SEL2_TCK);
         default: return 6'(GUARD_MAX_TCK);
      endcase
   endfunction : guard_tck

   // Stretch window in ms, converted to tach ticks
   function automatic logic [16:0] stretch_tck(input logic [2:0] sel);
      int ms;
      unique case (sel)
         3'h1: ms = 50;
         3'h2: ms = 100;
         3'h3: ms = 200;
         3'h4: ms = 400;
         3'h5: ms = 600;
         3'h6: ms = 800;
         3'h7: ms = 950;
         default: ms = 0;
      endcase
      return 17'(ms * (TCLK_HZ / 1000));
   endfunction : stretch_tck

   // Fixed association: third PWM serves the last two fans
   function automatic int pwm_of_fan(input int fan);
      return (fan < NPWM) ? fan : NPWM - 1;
   endfunction : pwm_of_fan

endpackage : fts_pkg

// ==== hw/fts_pwm.sv ====
module fts_pwm (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_step,
   input wire logic [7:0] i_duty,
   input wire logic i_stretch,
   output logic o_pwm
);
   logic [7:0] step_r;
   logic [7:0] step_nxt;

   assign step_nxt = 8'(step_r + 8'h01);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         step_r <= 8'h00;
      end else if (i_step) begin
         step_r <= step_nxt;
      end
   end

   // Full duty still drops for one step in 256
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pwm <= 1'b0;
      end else if (i_stretch) begin
         o_pwm <= 1'b1;
      end else if (i_step) begin
         o_pwm <= (step_nxt < i_duty);
      end
   end

   AST_FULL_DUTY_GAP: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_step && step_r == 8'hFE && i_duty == 8'hFF && !i_stretch) |=> !o_pwm)
      else $error("Full duty did not leave its off step");

endmodule : fts_pwm

// ==== hw/fts_tach.sv ====
module fts_tach (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_tick,
   input wire logic i_tach,
   input wire logic i_pwm_on,
   input wire fts_pkg::fts_opt_type i_opt,
   output logic [15:0] o_reading,
   output logic o_stretch_req
);
   typedef enum logic [1:0] {ST_IDLE, ST_GUARD, ST_MEAS} fts_state_type;
   fts_state_type state_r;
   logic [16:0] win_r;
   logic [15:0] cnt_r;
   logic [3:0] edges_r;
   logic tach_d_r;
   logic pwm_d_r;
   logic stalled_r;
   logic tach_edge;
   logic done;
   logic win_end;
   logic [3:0] need;
   logic [16:0] str_tck;
   logic [15:0] fail_code;

   assign tach_edge = i_tach ^ tach_d_r;
   assign need = fts_pkg::edge_need(i_opt.edges);
   assign str_tck = fts_pkg::stretch_tck(i_opt.stretch);
   assign done = tach_edge && (4'(edges_r + 4'h1) == need);
   // Window is on-time after guard, or the stretch period when chosen
   assign win_end = (str_tck == 17'h0_0000) ? !i_pwm_on : (win_r >= str_tck);
   assign fail_code = (edges_r == 4'h0) ? fts_pkg::STALL_CODE :
      (i_opt.slow ? fts_pkg::STALL_CODE : fts_pkg::SLOW_CODE);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tach_d_r <= 1'b0;
         pwm_d_r <= 1'b0;
      end else begin
         tach_d_r <= i_tach;
         pwm_d_r <= i_pwm_on;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= ST_IDLE;
         win_r <= 17'h0_0000;
         cnt_r <= 16'h0000;
         edges_r <= 4'h0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (i_pwm_on && !pwm_d_r) begin
                  state_r <= ST_GUARD;
                  win_r <= 17'h0_0000;
               end else if (stalled_r && tach_edge && i_pwm_on) begin
                  state_r <= ST_MEAS;
                  win_r <= 17'h0_0000;
                  cnt_r <= 16'h0000;
                  edges_r <= 4'h1;
               end
            end
            ST_GUARD: begin
               if (!i_pwm_on) begin
                  state_r <= ST_IDLE;
               end else if (win_r >= {11'h000, fts_pkg::guard_tck(i_opt.guard)}) begin
                  state_r <= ST_MEAS;
                  win_r <= 17'h0_0000;
                  cnt_r <= 16'h0000;
                  edges_r <= 4'h0;
               end else if (i_tick) begin
                  win_r <= 17'(win_r + 17'h0_0001);
               end
            end
            ST_MEAS: begin
               if (done || win_end || cnt_r == 16'hFFFF) begin
                  state_r <= ST_IDLE;
               end else begin
                  if (tach_edge) begin
                     edges_r <= 4'(edges_r + 4'h1);
                  end
                  if (i_tick) begin
                     win_r <= 17'(win_r + 17'h0_0001);
                     if (edges_r != 4'h0) begin
                        cnt_r <= 16'(cnt_r + 16'h0001);
                     end
                  end
               end
            end
         endcase
      end
   end

   // Only whole counts or fail codes reach the reading
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_reading <= fts_pkg::STALL_CODE;
         stalled_r <= 1'b0;
      end else if (state_r == ST_MEAS) begin
         if (done) begin
            o_reading <= cnt_r;
            stalled_r <= 1'b0;
         end else if (win_end || cnt_r == 16'hFFFF) begin
            o_reading <= fail_code;
            stalled_r <= (edges_r == 4'h0);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_stretch_req <= 1'b0;
      end else begin
         o_stretch_req <= (state_r != ST_IDLE) && (str_tck != 17'h0_0000);
      end
   end

   sequence seq_end_no_edge;
      state_r == ST_MEAS && edges_r == 4'h0 && !tach_edge && win_end;
   endsequence

   sequence seq_end_slow;
      state_r == ST_MEAS && edges_r != 4'h0 && !done && (win_end || cnt_r == 16'hFFFF);
   endsequence

   AST_STALL_CODE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      seq_end_no_edge |=> (o_reading == 16'hFFFF && stalled_r))
      else $error("Stall did not load the all-ones code");

   AST_SLOW_CODE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      seq_end_slow |=> (o_reading == ($past(i_opt.slow) ? 16'hFFFF : 16'hFFFE)))
      else $error("Slow fan loaded the wrong code");

   AST_GUARD_MIN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (state_r == ST_GUARD ##1 state_r == ST_MEAS) |-> $past(win_r) >= 17'd8)
      else $error("Guard time ended early");

   AST_STALL_HOLD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (stalled_r && state_r == ST_IDLE && !tach_edge) |=> $stable(o_reading))
      else $error("Stalled reading changed without a new edge");

endmodule : fts_tach

// ==== test/fts_fan_model.sv ====
module fts_fan_model #(
   parameter int MODE = 1,
   parameter int HALF_NS = 55_500,
   parameter int FIRST_NS = 100_000
) (
   output logic o_tach
);
   timeunit 1ns;
   timeprecision 1ps;

   // Mode 0 seized, 1 spinning, 2 one edge then stuck
   initial begin
      o_tach = 1'b1;
      if (MODE != 0) begin
         #(FIRST_NS);
         o_tach = 1'b0;
         if (MODE == 1) begin
            forever #(HALF_NS) o_tach = ~o_tach;
         end
      end
   end
endmodule : fts_fan_model

// ==== test/test_fts_fan_monitor.sv ====
module test_fts_fan_monitor;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk;
   logic arst_n;
   fts_pkg::fts_reg_req_type reg_req;
   wire [3:0] tach;
   logic [7:0] rdata;
   logic [2:0] pwm;
   logic int_n;
   logic [15:0] v;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;

   fts_fan_monitor uut (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_REG(reg_req), .I_TACH(tach),
      .O_REG_RDATA(rdata), .O_PWM(pwm), .O_FAN_INT_N(int_n));
   fts_fan_model #(.MODE(1), .HALF_NS(55_500), .FIRST_NS(100_000)) fan1 (.o_tach(tach[0]));
   fts_fan_model #(.MODE(0)) fan2 (.o_tach(tach[1]));
   fts_fan_model #(.MODE(2), .FIRST_NS(150_000)) fan3 (.o_tach(tach[2]));
   fts_fan_model #(.MODE(2), .FIRST_NS(150_000)) fan4 (.o_tach(tach[3]));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic print_verdict();
      $display("compared=%0d fails=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // Whole run needs about 14400 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails = fails + 1;
         print_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Tach edges are not locked to the tick, so allow one tick either way
   task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      n_compared++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      reg_req.wr = 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      reg_req.rd = 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk({8'h00, d}, {8'h00, exp});
   endtask : rd_chk

   // Low byte first so the high byte comes from the same sample
   task automatic rd_tach(input logic [7:0] n, output logic [15:0] r);
      logic [7:0] lo;
      logic [7:0] hi;
      rd_reg(8'h28 + 8'(2 * n), lo);
      rd_reg(8'h29 + 8'(2 * n), hi);
      r = {hi, lo};
   endtask : rd_tach

   initial begin
      arst_n = 1'b0;
      reg_req = '0;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      rd_chk(8'h80, 8'h3C);
      rd_chk(8'h90, 8'h00);
      rd_chk(8'h10, 8'h00);
      wr_reg(8'h30, 8'hFF);
      wr_reg(8'h31, 8'h04);
      wr_reg(8'h32, 8'h04);
      wr_reg(8'h93, 8'h01);
      wr_reg(8'h54, 8'h01);
      wr_reg(8'h55, 8'h00);
      wr_reg(8'h5A, 8'h01);
      wr_reg(8'h5B, 8'h00);
      wr_reg(8'h80, 8'h1C);
      wr_reg(8'h28, 8'h55);
      rd_chk(8'h5A, 8'h01);
      // Short windows on the second and third outputs close near tick 16
      repeat (12000) @(negedge clk);
      chk({13'h0000, pwm}, 16'h0001);
      chk({15'h0000, int_n}, 16'h0001);
      // Stalled second fan gets its limit only while its output is off
      wr_reg(8'h56, 8'h00);
      wr_reg(8'h57, 8'h10);
      wr_reg(8'h80, 8'h9C);
      repeat (3) @(negedge clk);
      chk({15'h0000, int_n}, 16'h0000);
      // Drop the first output and wait past its next step
      wr_reg(8'h30, 8'h00);
      repeat (2300) @(negedge clk);
      chk({13'h0000, pwm}, 16'h0000);
      rd_chk(8'h42, 8'h04);
      rd_chk(8'h42, 8'h00);
      repeat (3) @(negedge clk);
      chk({15'h0000, int_n}, 16'h0001);
      rd_tach(8'h00, v);
      chk_rng(v, 16'h0004, 16'h0006);
      rd_tach(8'h01, v);
      chk(v, 16'hFFFF);
      rd_tach(8'h02, v);
      chk(v, 16'hFFFE);
      rd_tach(8'h03, v);
      chk(v, 16'hFFFF);
      print_verdict();
   end
endmodule : test_fts_fan_monitor
